// [core/valve_prove_pkg.sv]
package valve_prove_pkg;

    localparam int unsigned CLK_HZ         = 10_000_000;
    localparam int unsigned VENT_TIME_S    = 4;
    localparam int unsigned SETTLE_TIME_S  = 3;
    localparam int unsigned FILL_TIME_S    = 4;
    localparam int unsigned TICK_CYCLES    = CLK_HZ;
    localparam int unsigned TICK_W         = 24;

    // Test time code: 0..60 -> seconds, 61..114 -> 70..600 s, 115..164 -> 11..60 min
    localparam int unsigned CODE_W         = 8;
    localparam int unsigned CODE_SEC_MAX   = 60;
    localparam int unsigned CODE_TEN_MAX   = 114;
    localparam int unsigned CODE_MIN_MAX   = 164;
    localparam int unsigned SECS_W         = 12;

    typedef enum logic [2:0] {
        SCHED_NEVER  = 3'h0,
        SCHED_BEFORE = 3'h1,
        SCHED_AFTER  = 3'h2,
        SCHED_BOTH   = 3'h3,
        SCHED_SPLIT  = 3'h4
    } schedule_t;

    localparam schedule_t SCHED_RESET = SCHED_NEVER;

    typedef enum logic [2:0] {
        ST_IDLE     = 3'b000,
        ST_VENT     = 3'b001,
        ST_SETTLE_L = 3'b011,
        ST_WATCH_L  = 3'b010,
        ST_FILL     = 3'b110,
        ST_SETTLE_H = 3'b111,
        ST_WATCH_H  = 3'b101,
        ST_LOCKOUT  = 3'b100
    } state_t;

endpackage

// [core/second_timer.sv]
`timescale 1ns/1ps
// Counts whole seconds from a restart; done stays high once the target is reached.
module second_timer #(
    parameter int unsigned TICKS  = 10_000_000,
    parameter int unsigned TW     = 24,
    parameter int unsigned SW     = 12
) (
    input  wire logic          sys_clk,
    input  wire logic          rst,
    input  wire logic          restart,
    input  wire logic [SW-1:0] target,
    output logic               done
);
    logic [TW-1:0] tick;
    logic [SW-1:0] secs;

    if (TICKS < 2 || TICKS > (1 << TW)) begin : g_bad_ticks
        $error("second_timer: TICKS does not fit");
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            tick <= '0;
            secs <= '0;
        end else if (restart) begin
            tick <= '0;
            secs <= '0;
        end else if (tick == TW'(TICKS - 1)) begin
            tick <= '0;
            if (secs != target) begin
                secs <= secs + SW'(1);
            end
        end else begin
            tick <= tick + TW'(1);
        end
    end

    // Restart clears the count on the step change edge, so done must not look back at it
    assign done = (secs == target);
endmodule

// [core/valve_seat_proving_sequencer.sv]
`timescale 1ns/1ps
// Notes on behaviour
// - Five schedules; never is default, no test
// - Before schedule runs alongside pre-purge
// - After schedule runs after run, before dropout
// - Both schedule tests at before and after
// - Split: high test before, low test after
// - Proving enabled only while demand asserted
// - Programmable test duration sets watch time
// - All timings within ten percent tolerance
// - Vent: downstream open four seconds, upstream shut
// - Three second settle, switch ignored
// - Low watch: switch on means lockout
// - Fill: upstream open four seconds, downstream shut
// - Second three second settle, switch ignored
// - High watch: switch off means lockout
// - Six steps in fixed order
// - Test time in 1s/10s/1min steps
module valve_seat_proving_sequencer
    import valve_prove_pkg::*;
#(
    parameter int unsigned TICK_PER_S = TICK_CYCLES
) (
    input  wire logic                          sys_clk,
    input  wire logic                          rst,
    input  wire valve_prove_pkg::schedule_t    schedule,
    input  wire logic [valve_prove_pkg::CODE_W-1:0] test_time_code,
    input  wire logic                          demand,
    input  wire logic                          prepurge_start,
    input  wire logic                          run_end,
    input  wire logic                          seat_pressure_switch,
    output logic                               upstream_valve_out,
    output logic                               downstream_valve_out,
    output logic                               proving_busy,
    output logic                               proving_done,
    output logic                               lockout,
    output logic                               leak_upstream,
    output logic                               leak_downstream
);
    import valve_prove_pkg::*;

    state_t             state;
    state_t             next_state;
    logic [1:0]         sw_sync;
    logic [1:0]         dem_sync;
    logic               sw_level;
    logic               dem_level;
    logic               low_only;
    logic               restart;
    logic               timer_done;
    logic [SECS_W-1:0]  target;
    logic [SECS_W-1:0]  test_secs;
    logic               start_before;
    logic               start_after;

    // Refuse settings that the timer or the test time decode cannot hold
    if (TICK_PER_S < 2 || TICK_PER_S > (1 << TICK_W)) begin : g_bad_tick
        $error("tick count per second does not fit the timer");
    end
    if (CODE_MIN_MAX >= (1 << CODE_W)) begin : g_bad_code
        $error("test time code field too narrow");
    end
    if ((1 << SECS_W) <= 3600) begin : g_bad_secs
        $error("seconds count too narrow for one hour");
    end

    // Two-stage synchronisers for pins; stage 0 feeds stage 1 only
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            sw_sync  <= '0;
            dem_sync <= '0;
        end else begin
            sw_sync  <= {sw_sync[0], seat_pressure_switch};
            dem_sync <= {dem_sync[0], demand};
        end
    end
    assign sw_level  = sw_sync[1];
    assign dem_level = dem_sync[1];

    // Decode test time code into seconds
    always_comb begin
        if (test_time_code <= CODE_W'(CODE_SEC_MAX)) begin
            test_secs = SECS_W'(test_time_code);
        end else if (test_time_code <= CODE_W'(CODE_TEN_MAX)) begin
            test_secs = SECS_W'((32'(test_time_code) - CODE_SEC_MAX) * 10 + 60);
        end else if (test_time_code <= CODE_W'(CODE_MIN_MAX)) begin
            test_secs = SECS_W'((32'(test_time_code) - CODE_TEN_MAX) * 60 + 600);
        end else begin
            // Codes past the top clamp to one hour
            test_secs = SECS_W'(3600);
        end
    end

    // Schedule points; proving needs demand
    assign start_before = prepurge_start && dem_level &&
        (schedule == SCHED_BEFORE || schedule == SCHED_BOTH ||
         schedule == SCHED_SPLIT);
    assign start_after = run_end && dem_level &&
        (schedule == SCHED_AFTER || schedule == SCHED_BOTH ||
         schedule == SCHED_SPLIT);

    // Split mode: remember which half runs this time
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            low_only  <= 1'b0;
        end else if (state == ST_IDLE && (start_before || start_after)) begin
            low_only  <= !start_before && schedule == SCHED_SPLIT;
        end
    end

    always_comb begin
        case (state)
            ST_VENT:                   target = SECS_W'(VENT_TIME_S);
            ST_FILL:                   target = SECS_W'(FILL_TIME_S);
            ST_SETTLE_L, ST_SETTLE_H:  target = SECS_W'(SETTLE_TIME_S);
            ST_WATCH_L, ST_WATCH_H:    target = test_secs;
            default:                   target = '0;
        endcase
    end

    // Timing is clock exact, well within the tolerance band
    second_timer #(
        .TICKS (TICK_PER_S),
        .TW    (TICK_W),
        .SW    (SECS_W)
    ) u_timer (
        .sys_clk (sys_clk),
        .rst     (rst),
        .restart (restart),
        .target  (target),
        .done    (timer_done)
    );

    // Step sequencer; each timed step leaves once its second count is reached
    always_comb begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (start_before || start_after) begin
                    // Split before point goes straight to pressurise
                    next_state = (start_before && schedule == SCHED_SPLIT) ?
                                 ST_FILL : ST_VENT;
                end
            end
            ST_VENT:     if (timer_done) next_state = ST_SETTLE_L;
            ST_SETTLE_L: if (timer_done) next_state = ST_WATCH_L;
            ST_WATCH_L: begin
                // Switch level lags its pin by two clocks
                if (sw_level) begin
                    next_state = ST_LOCKOUT;
                end else if (timer_done) begin
                    next_state = low_only ? ST_IDLE : ST_FILL;
                end
            end
            ST_FILL:     if (timer_done) next_state = ST_SETTLE_H;
            ST_SETTLE_H: if (timer_done) next_state = ST_WATCH_H;
            ST_WATCH_H: begin
                if (!sw_level) begin
                    next_state = ST_LOCKOUT;
                end else if (timer_done) begin
                    next_state = ST_IDLE;
                end
            end
            ST_LOCKOUT:  next_state = ST_LOCKOUT;
            default:     next_state = ST_LOCKOUT;
        endcase
    end

    // Any step change restarts the second count
    assign restart = (next_state != state);

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            state <= ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // Valve drive straight from flops, closed in every other step
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            upstream_valve_out   <= 1'b0;
            downstream_valve_out <= 1'b0;
        end else begin
            downstream_valve_out <= (next_state == ST_VENT);
            upstream_valve_out   <= (next_state == ST_FILL);
        end
    end

    // Busy and done follow the next state so they line up with the valves
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            proving_busy <= 1'b0;
        end else begin
            proving_busy <= (next_state != ST_IDLE) && (next_state != ST_LOCKOUT);
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            proving_done <= 1'b0;
        end else begin
            proving_done <= (state != ST_IDLE) && (next_state == ST_IDLE);
        end
    end

    // Lockout and its cause latch on entry and hold until reset
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            lockout         <= 1'b0;
            leak_upstream   <= 1'b0;
            leak_downstream <= 1'b0;
        end else if (state != ST_LOCKOUT && next_state == ST_LOCKOUT) begin
            lockout         <= 1'b1;
            leak_upstream   <= (state == ST_WATCH_L);
            leak_downstream <= (state == ST_WATCH_H);
        end
    end
endmodule

// [verification/prove_asserts.sv]
`timescale 1ns/1ps
module prove_asserts
    import valve_prove_pkg::*;
#(
    parameter int unsigned TICK_PER_S = 10
) (
    input wire logic      sys_clk,
    input wire logic      rst,
    input wire schedule_t schedule,
    input wire logic      demand,
    input wire logic      seat_pressure_switch,
    input wire logic      upstream_valve_out,
    input wire logic      downstream_valve_out,
    input wire logic      proving_busy,
    input wire logic      proving_done,
    input wire logic      lockout,
    input wire logic      leak_upstream,
    input wire logic      leak_downstream
);
    import valve_prove_pkg::*;
    // Open-valve spans may stray by a tenth either way
    localparam int unsigned VLO = VENT_TIME_S * TICK_PER_S * 9 / 10;
    localparam int unsigned VHI = VENT_TIME_S * TICK_PER_S * 11 / 10;
    localparam int unsigned FLO = FILL_TIME_S * TICK_PER_S * 9 / 10;
    localparam int unsigned FHI = FILL_TIME_S * TICK_PER_S * 11 / 10;
    logic [31:0] dn_n;
    logic [31:0] up_n;
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) dn_n <= '0;
        else dn_n <= downstream_valve_out ? dn_n + 32'h1 : '0;
    end
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) up_n <= '0;
        else up_n <= upstream_valve_out ? up_n + 32'h1 : '0;
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    valves_exclusive_a: assert property (
        !(upstream_valve_out && downstream_valve_out))
        else $error("both valves open");
    valve_busy_a: assert property (
        (upstream_valve_out || downstream_valve_out) |-> proving_busy)
        else $error("valve open while idle");
    lockout_closed_a: assert property (
        lockout |-> !upstream_valve_out && !downstream_valve_out)
        else $error("valve open in lockout");
    lockout_sticky_a: assert property (lockout |=> lockout)
        else $error("lockout released");
    vent_time_a: assert property (
        $fell(downstream_valve_out) |-> dn_n >= VLO && dn_n <= VHI)
        else $error("vent span wrong");
    fill_time_a: assert property (
        $fell(upstream_valve_out) |-> up_n >= FLO && up_n <= FHI)
        else $error("fill span wrong");
    done_closed_a: assert property (
        proving_done |-> !upstream_valve_out && !downstream_valve_out && !lockout
        ##1 !proving_done)
        else $error("done with valve open");
    demand_gate_a: assert property ($rose(proving_busy) |-> $past(demand, 3))
        else $error("test started without demand");
    never_idle_a: assert property (schedule == SCHED_NEVER |-> !proving_busy)
        else $error("test under never schedule");
    leak_up_a: assert property ($rose(leak_upstream) |-> $past(seat_pressure_switch, 3))
        else $error("upstream leak without pressure");
    leak_dn_a: assert property (
        $rose(leak_downstream) |-> !$past(seat_pressure_switch, 3))
        else $error("downstream leak with pressure");
    cover property (proving_done);
    cover property ($rose(leak_upstream));
    cover property ($rose(leak_downstream));
endmodule
bind valve_seat_proving_sequencer prove_asserts #(.TICK_PER_S(TICK_PER_S)) chk_u (
    .sys_clk, .rst, .schedule, .demand, .seat_pressure_switch, .upstream_valve_out,
    .downstream_valve_out, .proving_busy, .proving_done, .lockout, .leak_upstream,
    .leak_downstream);

// [verification/gas_train_model.sv]
`timescale 1ns/1ps
module gas_train_model (
    input  wire logic sys_clk,
    input  wire logic rst,
    input  wire logic upstream_valve_out,
    input  wire logic downstream_valve_out,
    input  wire logic leak_up,
    input  wire logic leak_dn,
    output logic      seat_pressure_switch
);
    // Space between the seats; switch is high while pressure is present
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) seat_pressure_switch <= 1'b0;
        else if (downstream_valve_out) seat_pressure_switch <= 1'b0;
        else if (upstream_valve_out) seat_pressure_switch <= 1'b1;
        else if (leak_up) seat_pressure_switch <= 1'b1;
        else if (leak_dn) seat_pressure_switch <= 1'b0;
    end
endmodule

// [verification/tb.sv]
`timescale 1ns/1ps
module tb;
    import valve_prove_pkg::*;
    localparam int TPS = 10;
    logic sys_clk, rst, demand, prepurge_start, run_end, leak_up, leak_dn, sw;
    logic up_v, dn_v, busy, done, lockout, leak_u, leak_d;
    schedule_t schedule;
    logic [CODE_W-1:0] code;
    int fails, n_compared, tno;
    valve_seat_proving_sequencer #(.TICK_PER_S(TPS)) dut_u (.sys_clk(sys_clk), .rst(rst),
        .schedule(schedule), .test_time_code(code), .demand(demand),
        .prepurge_start(prepurge_start), .run_end(run_end), .seat_pressure_switch(sw),
        .upstream_valve_out(up_v), .downstream_valve_out(dn_v), .proving_busy(busy),
        .proving_done(done), .lockout(lockout), .leak_upstream(leak_u),
        .leak_downstream(leak_d));
    gas_train_model model_u (.sys_clk(sys_clk), .rst(rst), .upstream_valve_out(up_v),
        .downstream_valve_out(dn_v), .leak_up(leak_up), .leak_dn(leak_dn),
        .seat_pressure_switch(sw));
    task automatic print_verdict;
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic check_bit(logic got, logic exp, string what);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("mismatch at %0t: %s", $time, what);
        end
    endtask
    task automatic check_cnt(int got, int exp);
        n_compared++;
        if (got < exp - exp / 10 - 3 || got > exp + exp / 10 + 3) begin
            fails++;
            $display("mismatch at %0t: span %0d not near %0d", $time, got, exp);
        end
    endtask
    function automatic int secs(int c);
        if (c <= 60) return c;
        if (c <= 114) return 60 + (c - 60) * 10;
        if (c <= 164) return 600 + (c - 114) * 60;
        return 3600;
    endfunction
    task automatic pulse(bit aft);
        if (aft) run_end = 1'b1;
        else prepurge_start = 1'b1;
        @(negedge sys_clk);
        run_end = 1'b0;
        prepurge_start = 1'b0;
    endtask
    task automatic run_test(schedule_t s, bit aft, int c, bit dem, bit lu, bit ld);
        int n, w, e;
        bit lo, hi;
        @(negedge sys_clk);
        schedule = s;
        code = CODE_W'(c);
        demand = dem;
        leak_up = lu;
        leak_dn = ld;
        repeat (4) @(negedge sys_clk);
        lo = dem && (aft ? s inside {SCHED_AFTER, SCHED_BOTH, SCHED_SPLIT}
                         : s inside {SCHED_BEFORE, SCHED_BOTH});
        hi = dem && (aft ? s inside {SCHED_AFTER, SCHED_BOTH}
                         : s inside {SCHED_BEFORE, SCHED_BOTH, SCHED_SPLIT});
        w = secs(c) ? secs(c) * TPS : 1;
        e = int'(lo) * ((VENT_TIME_S + SETTLE_TIME_S) * TPS + w)
            + int'(hi) * ((FILL_TIME_S + SETTLE_TIME_S) * TPS + w);
        pulse(aft);
        n = 1;
        while (done !== 1'b1 && lockout !== 1'b1 && n < e + e / 10 + 10) begin
            @(negedge sys_clk);
            n++;
        end
        if ((lo && lu) || (hi && ld)) begin
            check_bit(lockout, 1'b1, "no lockout");
            check_bit(leak_u, lo && lu, "upstream leak flag");
            check_bit(leak_d, !(lo && lu), "downstream leak flag");
            pulse(aft);
            repeat (10) @(negedge sys_clk);
            check_bit(lockout, 1'b1, "lockout cleared");
            check_bit(up_v | dn_v, 1'b0, "valve open in lockout");
            rst = 1'b1;
            repeat (2) @(negedge sys_clk);
            rst = 1'b0;
            repeat (3) @(negedge sys_clk);
        end else if (e > 0) begin
            check_cnt(n, e);
            check_bit(up_v | dn_v, 1'b0, "valve open after pass");
            check_bit(done, 1'b1, "no done pulse");
            check_bit(busy, 1'b0, "busy after pass");
        end else begin
            check_bit(busy, 1'b0, "test ran unexpectedly");
        end
        tno++;
        $display("test %0d schedule %0d point %0d done", tno, s, aft);
    endtask
    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end
    initial begin
        repeat (30000) @(posedge sys_clk);
        fails++;
        print_verdict();
    end
    initial begin
        {rst, demand, prepurge_start, run_end, leak_up, leak_dn} = 6'h20;
        {fails, n_compared, tno} = '0;
        schedule = SCHED_NEVER;
        code = '0;
        void'($urandom(32'h1da8));
        repeat (5) @(negedge sys_clk);
        rst = 1'b0;
        repeat (3) @(negedge sys_clk);
        for (int i = 0; i < 10; i++) begin
            int c;
            c = $urandom_range(0, 4);
            run_test(schedule_t'(i % 5), i / 5, c, 1, 0, 0);
        end
        run_test(SCHED_BOTH, 0, 61, 1, 0, 0);
        run_test(SCHED_SPLIT, 1, 115, 1, 0, 0);
        run_test(SCHED_BEFORE, 0, 2, 0, 0, 0);
        run_test(SCHED_BOTH, 1, $urandom_range(1, 3), 1, 1, 0);
        run_test(SCHED_BEFORE, 0, 0, 1, 0, 1);
        run_test(SCHED_SPLIT, 1, 2, 1, 0, 1);
        run_test(SCHED_SPLIT, 0, 2, 1, 1, 0);
        print_verdict();
    end
endmodule
